// [src/bsf_defs.svh]
`ifndef BSF_DEFS_SVH
`define BSF_DEFS_SVH

`define BSF_ADDR_W 8
`define BSF_OFF_RX_DATA 8'h00
`define BSF_OFF_TX_DATA 8'h04
`define BSF_OFF_CTRL 8'h08
`define BSF_OFF_STATUS 8'h0C
`define BSF_OFF_CLK_RATIO 8'h10
`define BSF_OFF_IRQ_STAT 8'h14
`define BSF_OFF_IRQ_MASK 8'h18

`define BSF_RST_RX_DATA 16'h0000
`define BSF_RST_CLK_RATIO 16'h0006
`define BSF_RST_CTRL 16'h0000

`define BSF_FIFO_DEPTH 10
`define BSF_DEPTH_MAX 4'h9

`define BSF_CTRL_EN 0
`define BSF_CTRL_MASTER_SELECT_BIT 1
`define BSF_CTRL_RIE_LO 2
`define BSF_CTRL_WL16 4
`define BSF_CTRL_RXD_LO 8
`define BSF_CTRL_TXD_LO 12

`define BSF_ST_FIFO_DISABLE_BIT 0
`define BSF_ST_BUS_ERROR_FLAG 2
`define BSF_ST_RECEIVE_NOT_EMPTY_FLAG 3
`define BSF_ST_RFF 4
`define BSF_ST_TFF 8
`define BSF_ST_TFNE 9

`define BSF_IRQ_RECEIVE_NOT_EMPTY_FLAG 0
`define BSF_IRQ_RFF 1
`define BSF_IRQ_BUS_ERROR_FLAG 2

`define BSF_RIE_RECEIVE_NOT_EMPTY_FLAG 2'h1
`define BSF_RIE_RFF 2'h3

`endif

// [src/bsf_pkg.sv]
package bsf_pkg;
    typedef enum logic {BSF_IDLE, BSF_RUN} bsf_state_t;
endpackage : bsf_pkg

// [src/bsf_top.sv]
`include "bsf_defs.svh"

module bsf_top
    import bsf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    input wire logic sclk_i,
    output logic sclk_o,
    output logic sclk_oe_o,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe_o,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic ss_n_i
);
    logic [15:0] ctrl;
    logic [15:0] clk_ratio;
    logic fifo_disable_bit;
    logic bus_error_flag;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [1:0] sclk_sy, mosi_sy, miso_sy, ss_sy;
    logic sclk_d;
    bsf_state_t state;
    logic [15:0] shreg;
    logic out_bit;
    logic [4:0] bit_cnt;
    logic [7:0] div_cnt;
    logic sclk_m;
    logic [15:0] rx_mem [0:`BSF_FIFO_DEPTH-1];
    logic [15:0] tx_mem [0:`BSF_FIFO_DEPTH-1];
    logic [3:0] rx_wp, rx_rp, tx_wp, tx_rp;
    logic [3:0] rx_cnt, tx_cnt;
    logic rff_d, receive_not_empty_flag_d;

    wire en = ctrl[`BSF_CTRL_EN];
    wire master_select_bit = ctrl[`BSF_CTRL_MASTER_SELECT_BIT];
    wire [1:0] rie = ctrl[`BSF_CTRL_RIE_LO +: 2];
    wire wl16 = ctrl[`BSF_CTRL_WL16];
    wire [3:0] rx_depth = ctrl[`BSF_CTRL_RXD_LO +: 4];
    wire [3:0] tx_depth = ctrl[`BSF_CTRL_TXD_LO +: 4];
    // out-of-range depth codes fall back to a single location
    wire [3:0] rx_cap = (rx_depth > `BSF_DEPTH_MAX) ? 4'h1 : rx_depth + 4'h1;
    wire [3:0] tx_cap = (tx_depth > `BSF_DEPTH_MAX) ? 4'h1 : tx_depth + 4'h1;
    wire receive_full_flag = (rx_cnt >= rx_cap) && (rx_cnt != 4'h0);
    wire receive_not_empty_flag = (rx_cnt != 4'h0);
    wire tff = (tx_cnt >= tx_cap);
    wire tfne = (tx_cnt != 4'h0);
    wire [4:0] nbits = wl16 ? 5'h10 : 5'h08;
    wire [7:0] half = (clk_ratio[7:0] < 8'h2) ? 8'h1 : {1'b0, clk_ratio[7:1]};

    wire wr_ctrl = wr_i && (addr_i == `BSF_OFF_CTRL);
    wire wr_stat = wr_i && (addr_i == `BSF_OFF_STATUS);
    wire rd_rx = rd_i && (addr_i == `BSF_OFF_RX_DATA);
    wire rd_irq = rd_i && (addr_i == `BSF_OFF_IRQ_STAT);
    wire tx_push = wr_i && (addr_i == `BSF_OFF_TX_DATA) && !tff;
    wire rx_pop = rd_rx && receive_not_empty_flag;

    // master edges come from the divider, slave edges from the synced pin
    wire m_tick = (state == BSF_RUN) && master_select_bit && (div_cnt == half - 8'h1);
    wire rise = master_select_bit ? (m_tick && !sclk_m) : (sclk_sy[1] && !sclk_d);
    wire fall = master_select_bit ? (m_tick && sclk_m) : (!sclk_sy[1] && sclk_d);
    wire din = master_select_bit ? miso_sy[1] : mosi_sy[1];
    wire start_m = en && master_select_bit && (state == BSF_IDLE) && tfne;
    wire start_s = en && !master_select_bit && (state == BSF_IDLE) && !ss_sy[1];
    wire start = start_m || start_s;
    wire done = (state == BSF_RUN) && fall && (bit_cnt == nbits);
    wire tx_pop = start && tfne;
    wire rx_push = done && (rx_cnt < rx_cap);
    wire [15:0] rx_word = wl16 ? shreg : {shreg[7:0], 8'h00};
    wire [15:0] tx_word = tfne ? tx_mem[tx_rp] : 16'h0000;

    // pin inputs: two flops before use
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_sy <= 2'h0;
            mosi_sy <= 2'h0;
            miso_sy <= 2'h0;
            ss_sy <= 2'h3;
            sclk_d <= 1'b0;
        end else begin
            sclk_sy <= {sclk_sy[0], sclk_i};
            mosi_sy <= {mosi_sy[0], mosi_i};
            miso_sy <= {miso_sy[0], miso_i};
            ss_sy <= {ss_sy[0], ss_n_i};
            sclk_d <= sclk_sy[1];
        end
    end

    // control register, depth fields forced to zero by a flush
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl <= `BSF_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl <= wdata_i;
        end else if (fifo_disable_bit) begin
            ctrl[`BSF_CTRL_RXD_LO +: 4] <= 4'h0;
            ctrl[`BSF_CTRL_TXD_LO +: 4] <= 4'h0;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clk_ratio <= `BSF_RST_CLK_RATIO;
        end else if (wr_i && addr_i == `BSF_OFF_CLK_RATIO) begin
            clk_ratio <= {8'h00, wdata_i[7:0]};
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fifo_disable_bit <= 1'b0;
        end else begin
            fifo_disable_bit <= wr_stat && wdata_i[`BSF_ST_FIFO_DISABLE_BIT];
        end
    end

    // sticky until a write of one; a new contention wins over the clear
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bus_error_flag <= 1'b0;
        end else if (en && master_select_bit && !ss_sy[1]) begin
            bus_error_flag <= 1'b1;
        end else if (wr_stat && wdata_i[`BSF_ST_BUS_ERROR_FLAG]) begin
            bus_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rff_d <= 1'b0;
            receive_not_empty_flag_d <= 1'b0;
        end else begin
            rff_d <= receive_full_flag;
            receive_not_empty_flag_d <= receive_not_empty_flag;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat <= 3'h0;
        end else begin
            irq_stat[`BSF_IRQ_RECEIVE_NOT_EMPTY_FLAG] <= (receive_not_empty_flag && !receive_not_empty_flag_d && rie == `BSF_RIE_RECEIVE_NOT_EMPTY_FLAG)
                || (irq_stat[`BSF_IRQ_RECEIVE_NOT_EMPTY_FLAG] && !rd_irq);
            irq_stat[`BSF_IRQ_RFF] <= (receive_full_flag && !rff_d && rie == `BSF_RIE_RFF)
                || (irq_stat[`BSF_IRQ_RFF] && !rd_irq);
            irq_stat[`BSF_IRQ_BUS_ERROR_FLAG] <= (en && master_select_bit && !ss_sy[1] && !bus_error_flag)
                || (irq_stat[`BSF_IRQ_BUS_ERROR_FLAG] && !rd_irq);
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_mask <= 3'h0;
        end else if (wr_i && addr_i == `BSF_OFF_IRQ_MASK) begin
            irq_mask <= wdata_i[2:0];
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_o <= `BSF_RST_RX_DATA;
        end else if (rd_i) begin
            unique case (addr_i)
                `BSF_OFF_RX_DATA: rdata_o <= receive_not_empty_flag ? rx_mem[rx_rp] : `BSF_RST_RX_DATA;
                `BSF_OFF_CTRL: rdata_o <= ctrl;
                `BSF_OFF_STATUS: rdata_o <= {6'h00, tfne, tff, 3'h0, receive_full_flag, receive_not_empty_flag, bus_error_flag,
                    1'b0, fifo_disable_bit};
                `BSF_OFF_CLK_RATIO: rdata_o <= clk_ratio;
                `BSF_OFF_IRQ_STAT: rdata_o <= {13'h0000, irq_stat};
                `BSF_OFF_IRQ_MASK: rdata_o <= {13'h0000, irq_mask};
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // a capacity of one makes the fifo the plain receive/transmit register
    always_ff @(posedge mclk_i) begin
        if (rx_push) begin
            rx_mem[rx_wp] <= rx_word;
        end
        if (tx_push) begin
            tx_mem[tx_wp] <= wdata_i;
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_cnt <= 4'h0;
        end else if (fifo_disable_bit) begin
            rx_wp <= 4'h0;
            rx_rp <= 4'h0;
            rx_cnt <= 4'h0;
        end else begin
            if (rx_push) begin
                rx_wp <= (rx_wp == `BSF_DEPTH_MAX) ? 4'h0 : rx_wp + 4'h1;
            end
            if (rx_pop) begin
                rx_rp <= (rx_rp == `BSF_DEPTH_MAX) ? 4'h0 : rx_rp + 4'h1;
            end
            rx_cnt <= rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};
        end
    end

    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_cnt <= 4'h0;
        end else if (fifo_disable_bit) begin
            tx_wp <= 4'h0;
            tx_rp <= 4'h0;
            tx_cnt <= 4'h0;
        end else begin
            if (tx_push) begin
                tx_wp <= (tx_wp == `BSF_DEPTH_MAX) ? 4'h0 : tx_wp + 4'h1;
            end
            if (tx_pop) begin
                tx_rp <= (tx_rp == `BSF_DEPTH_MAX) ? 4'h0 : tx_rp + 4'h1;
            end
            tx_cnt <= tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
        end
    end

    // serial clock divider: half the ratio per phase
    // held at zero outside frames, so the serial clock idles low
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt <= 8'h00;
            sclk_m <= 1'b0;
        end else if (state != BSF_RUN || !master_select_bit) begin
            div_cnt <= 8'h00;
            sclk_m <= 1'b0;
        end else if (m_tick) begin
            div_cnt <= 8'h00;
            sclk_m <= !sclk_m;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // sample on rising edge, present next bit on falling edge
    // a slave frame cut by select rising is dropped, nothing pushed
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= BSF_IDLE;
            shreg <= 16'h0000;
            out_bit <= 1'b0;
            bit_cnt <= 5'h00;
        end else begin
            unique case (state)
                BSF_IDLE: begin
                    if (start) begin
                        state <= BSF_RUN;
                        shreg <= tx_word;
                        out_bit <= tx_word[15];
                        bit_cnt <= 5'h00;
                    end
                end
                BSF_RUN: begin
                    if (!en || fifo_disable_bit || (!master_select_bit && ss_sy[1])) begin
                        state <= BSF_IDLE;
                    end else if (done) begin
                        state <= BSF_IDLE;
                    end else if (rise) begin
                        shreg <= {shreg[14:0], din};
                        bit_cnt <= bit_cnt + 5'h01;
                    end else if (fall) begin
                        out_bit <= shreg[15];
                    end
                end
            endcase
        end
    end

    assign sclk_o = sclk_m;
    assign sclk_oe_o = en && master_select_bit;
    assign mosi_o = out_bit;
    assign mosi_oe_o = en && master_select_bit;
    assign miso_o = out_bit;
    assign miso_oe_o = en && !master_select_bit && !ss_sy[1];

    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    chk_rx_full_set: assert property (
        (rx_push && !rx_pop && !fifo_disable_bit && !wr_ctrl && rx_cnt + 4'h1 == rx_cap) |=> receive_full_flag)
        else $error("receive full not set when fifo filled");
    chk_rff_irq: assert property (
        ($rose(receive_full_flag) && rie == `BSF_RIE_RFF) |=> irq_stat[`BSF_IRQ_RFF])
        else $error("receive full interrupt missing");
    chk_receive_not_empty_flag_set: assert property (
        (rx_push && rx_cnt == 4'h0 && !fifo_disable_bit) |=> receive_not_empty_flag ##0 rx_cnt == 4'h1)
        else $error("not empty not set after one word");
    chk_receive_not_empty_flag_irq: assert property (
        ($rose(receive_not_empty_flag) && rie == `BSF_RIE_RECEIVE_NOT_EMPTY_FLAG && irq_mask[0]) |=> ##1 irq_o)
        else $error("not empty interrupt missing");
    chk_bus_error_flag_sticky: assert property (
        (en && master_select_bit && !ss_sy[1]) |=> bus_error_flag [*2])
        else $error("bus error not raised or not held");
    chk_fifo_flush: assert property (
        (fifo_disable_bit && !wr_ctrl) |=> (rx_cnt == 4'h0 && tx_cnt == 4'h0 && rx_depth == 4'h0))
        else $error("fifo disable did not flush");
    chk_fifo_disable_bit_pulse: assert property (
        $rose(fifo_disable_bit) |=> !fifo_disable_bit || $past(wr_stat))
        else $error("fifo disable did not self clear");
    chk_sclk_half: assert property (
        $changed(sclk_m) && sclk_oe_o |-> $past(div_cnt) == half - 8'h1)
        else $error("serial clock phase length wrong");
    chk_rx_justify: assert property (
        (rx_push && !wl16) |=> rx_mem[$past(rx_wp)][7:0] == 8'h00)
        else $error("8-bit receive word not left justified");
    chk_ratio_reset: assert property (
        $fell(sys_rst_i) |-> clk_ratio == `BSF_RST_CLK_RATIO)
        else $error("ratio register reset value wrong");

    chk_rff_clear: assert property (
        (rx_pop && !rx_push && receive_full_flag && !fifo_disable_bit && !wr_ctrl) |=> !receive_full_flag)
        else $error("receive full not cleared by a read");

    chk_receive_not_empty_flag_clear: assert property (
        (rx_pop && !rx_push && rx_cnt == 4'h1 && !fifo_disable_bit) |=> !receive_not_empty_flag)
        else $error("not empty not cleared when drained");

    chk_bus_error_flag_clear: assert property (
        (wr_stat && wdata_i[`BSF_ST_BUS_ERROR_FLAG] && !(en && master_select_bit && !ss_sy[1])) |=> !bus_error_flag)
        else $error("bus error not cleared by software");

    chk_tx_count: assert property (
        (tx_push && !tx_pop && !fifo_disable_bit) |=> tx_cnt == $past(tx_cnt) + 4'h1)
        else $error("transmit write not taken into fifo");

endmodule : bsf_top

// [sim/bsf_spi_peer.sv]
module bsf_spi_peer (
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic sel_i,
    output logic miso_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] shift_reg;
    logic cap_bit;
    initial begin
        shift_reg = 16'h0000;
        cap_bit = 1'b0;
    end
    task automatic load(input logic [15:0] w);
        shift_reg = w;
    endtask : load
    // sample on rising, change on falling: a released line shows the inverse
    always @(posedge sclk_i) begin
        cap_bit <= mosi_i;
    end
    always @(negedge sclk_i) begin
        shift_reg <= {shift_reg[14:0], cap_bit};
    end
    assign miso_o = sel_i ? shift_reg[15] : ~shift_reg[15];
endmodule : bsf_spi_peer

// [sim/test_bsf_top.sv]
module test_bsf_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    logic irq_o;
    logic sclk_o, sclk_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, miso_w;
    logic ss_n_i = 1'b1;
    logic s_sclk = 1'b0;
    logic s_mosi = 1'b0;
    logic peer_sel = 1'b1;
    logic sclk_q = 1'b0;
    logic [15:0] sclk_cnt = 16'h0000;
    logic [15:0] sclk_per = 16'h0000;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] d;

    always #2.5 mclk_i = ~mclk_i;

    bsf_top i_bsf_top (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
        .sclk_i(s_sclk), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .mosi_i(s_mosi),
        .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o),
        .miso_oe_o(miso_oe_o), .ss_n_i(ss_n_i));
    bsf_spi_peer i_bsf_spi_peer (.sclk_i(sclk_o), .mosi_i(mosi_o), .sel_i(peer_sel),
        .miso_o(miso_w));

    // serial clock period in bus clock cycles, rising edge to rising edge
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        sclk_q <= sclk_o;
        sclk_cnt <= (sclk_o && !sclk_q) ? 16'h0001 : sclk_cnt + 16'h0001;
        if (sclk_o && !sclk_q) begin
            sclk_per <= sclk_cnt;
        end
        if (cycles == 50000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= w;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] r);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 r = rdata_o;
    endtask : rd

    // polls a status bit, bounded so a dead transfer cannot hang the run
    task automatic wait_bit(input int n, input logic v);
        logic [15:0] s;
        int i;
        for (i = 0; i < 500; i++) begin
            rd(8'h0C, s);
            if (s[n] === v) begin
                return;
            end
        end
        chk(s, 16'hDEAD);
    endtask : wait_bit

    task automatic t_reset_map();
        rd(8'h00, d);
        chk(d, 16'h0000);
        rd(8'h10, d);
        chk(d, 16'h0006);
        wr(8'h10, 16'hFFFF);
        rd(8'h10, d);
        chk(d, 16'h00FF);
        rd(8'h1C, d);
        chk(d, 16'h0000);
        wr(8'h10, 16'h0008);
    endtask : t_reset_map

    task automatic t_word16();
        i_bsf_spi_peer.load(16'h3C5A);
        wr(8'h18, 16'h0001);
        wr(8'h08, 16'h0017);
        wr(8'h04, 16'hA5C3);
        chk({13'h0000, sclk_oe_o, mosi_oe_o, miso_oe_o}, 16'h0006);
        wait_bit(3, 1'b1);
        chk(i_bsf_spi_peer.shift_reg, 16'hA5C3);
        chk(sclk_per, 16'h0008);
        // interrupt output trails the flag by two clocks
        repeat (2) @(posedge mclk_i);
        chk({15'h0000, irq_o}, 16'h0001);
        rd(8'h00, d);
        chk(d, 16'h3C5A);
        rd(8'h0C, d);
        chk({15'h0000, d[3]}, 16'h0000);
        rd(8'h14, d);
        chk(d & 16'h0001, 16'h0001);
        rd(8'h14, d);
        chk(d & 16'h0001, 16'h0000);
    endtask : t_word16

    task automatic t_word8();
        i_bsf_spi_peer.load(16'h5E00);
        wr(8'h08, 16'h0007);
        wr(8'h04, 16'hB7FF);
        wait_bit(3, 1'b1);
        chk({8'h00, i_bsf_spi_peer.shift_reg[7:0]}, 16'h00B7);
        rd(8'h00, d);
        chk(d, 16'h5E00);
        rd(8'h14, d);
    endtask : t_word8

    task automatic t_full_flush();
        i_bsf_spi_peer.load(16'h1234);
        wr(8'h18, 16'h0002);
        wr(8'h08, 16'h111F);
        wr(8'h04, 16'h8001);
        wr(8'h04, 16'h4002);
        wait_bit(4, 1'b1);
        repeat (2) @(posedge mclk_i);
        chk({15'h0000, irq_o}, 16'h0001);
        rd(8'h00, d);
        chk(d, 16'h1234);
        rd(8'h0C, d);
        chk({14'h0000, d[4:3]}, 16'h0001);
        wr(8'h0C, 16'h0001);
        rd(8'h08, d);
        chk({12'h000, d[11:8]}, 16'h0000);
        rd(8'h0C, d);
        chk({14'h0000, d[3], d[0]}, 16'h0000);
        rd(8'h14, d);
    endtask : t_full_flush

    task automatic t_bus_error();
        wr(8'h08, 16'h0003);
        @(posedge mclk_i);
        ss_n_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        ss_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        rd(8'h0C, d);
        chk({15'h0000, d[2]}, 16'h0001);
        rd(8'h0C, d);
        chk({15'h0000, d[2]}, 16'h0001);
        wr(8'h0C, 16'h0004);
        rd(8'h0C, d);
        chk({15'h0000, d[2]}, 16'h0000);
    endtask : t_bus_error

    // bench acts as master; four-clock phases outlast the pin synchroniser
    task automatic t_slave();
        logic [15:0] tx;
        logic [15:0] got;
        int i;
        tx = 16'h96E1;
        got = 16'h0000;
        wr(8'h08, 16'h0011);
        wr(8'h04, 16'hC36A);
        @(posedge mclk_i);
        ss_n_i <= 1'b0;
        repeat (5) @(posedge mclk_i);
        chk({13'h0000, sclk_oe_o, mosi_oe_o, miso_oe_o}, 16'h0001);
        for (i = 15; i >= 0; i--) begin
            s_mosi <= tx[i];
            repeat (4) @(posedge mclk_i);
            got[i] = miso_o;
            s_sclk <= 1'b1;
            repeat (4) @(posedge mclk_i);
            s_sclk <= 1'b0;
        end
        repeat (6) @(posedge mclk_i);
        ss_n_i <= 1'b1;
        chk(got, 16'hC36A);
        rd(8'h00, d);
        chk(d, 16'h96E1);
    endtask : t_slave

    initial begin
        repeat (5) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset_map();
        t_word16();
        t_word8();
        t_full_flush();
        t_bus_error();
        t_slave();
        report_and_stop();
    end
endmodule : test_bsf_top
